// [hdl/lvpm_pkg.sv]
package lvpm_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFS_PWR_CTRL_1 = 8'h00;
  localparam logic [7:0] OFS_PWR_CTRL_2 = 8'h04;
  localparam logic [7:0] OFS_PWR_CTRL_3 = 8'h08;
  localparam logic [7:0] OFS_RESET_STATUS = 8'h0c;
  localparam logic [7:0] OFS_CLOCK_CTRL = 8'h10;

  // Field positions in power_mgmt_ctrl_1
  localparam int B_DET_EN = 0;
  localparam int B_DET_STOP_EN = 1;
  localparam int B_DET_RST_EN = 2;
  localparam int B_DET_IRQ_EN = 3;
  localparam int B_DET_FLAG = 4;
  localparam int B_DET_ACK = 5;
  // Field positions in power_mgmt_ctrl_2
  localparam int B_STOP_DEEP_SEL = 0;
  localparam int B_STOP_INSTR_EN = 1;
  localparam int B_DEBUG_EN = 2;
  // Field positions in power_mgmt_ctrl_3
  localparam int B_THR_SEL = 0;
  localparam int B_WARN_SEL = 1;
  localparam int B_WARN_FLAG = 2;
  localparam int B_WARN_ACK = 3;
  // Field positions in reset_status_register
  localparam int B_RS_POR = 0;
  localparam int B_RS_LOW_SUPPLY = 1;
  localparam int B_RS_ILLEGAL_OP = 2;
  localparam int B_RS_STOP_WAKE = 3;

  // Reset values
  localparam logic [1:0] BUS_DIV_RESET = 2'h0;
  localparam logic [3:0] RSTAT_AT_POR = 4'h3;

  // Reset pseudo-vector, high then low byte
  localparam logic [15:0] RESET_VECTOR_HI = 16'hdffe;
  localparam logic [15:0] RESET_VECTOR_LO = 16'hdfff;

  // High-frequency oscillator rate at divide code 0 in kHz; low-frequency oscillator in Hz
  localparam int HFO_KHZ_CODE0 = 8000;
  localparam int LFO_HZ = 1000;

  // Indices of the asynchronous inputs
  localparam int NUM_ASYNC = 6;
  localparam int A_POR = 0;
  localparam int A_DET_HI = 1;
  localparam int A_DET_LO = 2;
  localparam int A_WARN_HI = 3;
  localparam int A_WARN_LO = 4;
  localparam int A_DBG_PIN = 5;
  // Synchroniser reset: power-on trip held, debug pin at idle high, until real samples agree
  localparam logic [NUM_ASYNC-1:0] SYNC_RESET = 6'h21;

  typedef enum logic [4:0] {
    ST_RESET = 5'b00001,
    ST_RUN = 5'b00010,
    ST_DEBUG = 5'b00100,
    ST_DEEP_STOP = 5'b01000,
    ST_RETAIN_STOP = 5'b10000
  } lvpm_state_type;

  typedef struct packed {
    logic det_irq_en;
    logic det_rst_en;
    logic det_stop_en;
    logic det_en;
  } lvpm_ctrl1_type;

  typedef struct packed {
    logic debug_en;
    logic stop_instr_en;
    logic stop_deep_sel;
  } lvpm_ctrl2_type;

  typedef struct packed {
    logic warn_sel;
    logic thr_sel;
  } lvpm_ctrl3_type;

endpackage

// [hdl/lvpm_ctrl.sv]
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Detector on with enable, or always in deep stop; select picks threshold
// - Retained stop disables detector unless stop-enable set
// - Either enable set forbids deepest stop
// - Power-on reset held until supply above threshold
// - Power-on sets both reset status flags
// - Reset enable: low supply resets, held while low
// - Low-supply reset sets its status flag
// - Interrupt mode: set detect flag, raise interrupt
// - Warning flag set low; ack clears when recovered
// - Warning never raises an interrupt
// - Two warning levels via level select
// - Divide field sets oscillator and bus rates
// - Every reset clears divide field
// - Debug pin high at reset: run, fetch vector
// - Four events enter active debug mode
// - Debug suspends CPU; intrusive commands only there
// - Stop without enable forces illegal-opcode reset
// - Stops halt clocks except low-frequency oscillator and, with debug enabled, system clock
// - Control register 2 selects stop mode
// - Deep stop exits by wake, restarts via reset
// - Deep stop arms detector; exit waits recovery
// - Pending interrupt refuses deep stop entry
// - Stop detector enabled redirects to retained stop
// - Debug enabled redirects, keeps system clock running
module lvpm_ctrl
  import lvpm_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic I_CLK_EN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_POR_TRIP,
  input wire logic I_DET_BELOW_HI,
  input wire logic I_DET_BELOW_LO,
  input wire logic I_WARN_BELOW_HI,
  input wire logic I_WARN_BELOW_LO,
  input wire logic I_DEBUG_MODE_PIN,
  input wire logic I_STOP_INSTR,
  input wire logic I_ENTER_DEBUG_INSTR,
  input wire logic I_BREAKPOINT_HIT,
  input wire logic I_IRQ_PENDING,
  input wire logic I_WAKE,
  input wire logic I_CMD_VALID,
  input wire logic I_CMD_INTRUSIVE,
  input wire logic I_CMD_BACKGROUND,
  input wire logic I_CMD_GO,
  output logic O_CMD_ACCEPT,
  output logic O_CMD_REJECT,
  output logic O_SYS_RESET,
  output logic O_LVD_IRQ,
  output logic [1:0] O_BUS_CLOCK_DIVIDE,
  output logic O_HFO_RUN,
  output logic O_SYS_CLK_RUN,
  output logic O_LFO_RUN,
  output logic O_CPU_SUSPEND,
  output logic O_REG_STANDBY,
  output logic O_VECTOR_FETCH,
  output logic [15:0] O_VECTOR_ADDR,
  output logic [4:0] O_MODE
);

  // Reset release through two flops; assertion stays asynchronous
  logic rst_s1_r;
  logic rst_n;
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // Three-stage sampling; a level counts once stages two and three agree
  logic [NUM_ASYNC-1:0] as1_r;
  logic [NUM_ASYNC-1:0] as2_r;
  logic [NUM_ASYNC-1:0] as3_r;
  logic [NUM_ASYNC-1:0] filt_r;
  wire [NUM_ASYNC-1:0] async_in = {I_DEBUG_MODE_PIN, I_WARN_BELOW_LO, I_WARN_BELOW_HI,
                                   I_DET_BELOW_LO, I_DET_BELOW_HI, I_POR_TRIP};
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      as1_r <= SYNC_RESET;
      as2_r <= SYNC_RESET;
      as3_r <= SYNC_RESET;
      filt_r <= SYNC_RESET;
    end else if (I_CLK_EN) begin
      as1_r <= async_in;
      as2_r <= as1_r;
      as3_r <= as2_r;
      filt_r <= (as2_r & as3_r) | (filt_r & (as2_r | as3_r));
    end
  end

  // Registers and state
  lvpm_ctrl1_type c1_r;
  lvpm_ctrl2_type c2_r;
  lvpm_ctrl3_type c3_r;
  logic [1:0] bus_div_r;
  logic det_flag_r;
  logic warn_flag_r;
  logic [3:0] rstat_r;
  logic por_hold_r;
  logic low_hold_r;
  logic ilop_r;
  logic wake_rst_r;
  logic por_seen_r;
  logic [31:0] prdata_r;
  lvpm_state_type st_r;
  lvpm_state_type st_nxt;

  // Threshold choice and detector gating
  wire in_stop = (st_r == ST_DEEP_STOP) || (st_r == ST_RETAIN_STOP);
  wire det_below = c3_r.thr_sel ? filt_r[A_DET_HI] : filt_r[A_DET_LO];
  wire warn_below = c3_r.warn_sel ? filt_r[A_WARN_HI] : filt_r[A_WARN_LO];
  wire det_active = (c1_r.det_en && (!in_stop || c1_r.det_stop_en))
                    || (st_r == ST_DEEP_STOP);
  wire por_trip = filt_r[A_POR];
  wire low_rst_req = det_active && c1_r.det_rst_en && det_below;
  wire det_irq_evt = det_active && c1_r.det_irq_en && !c1_r.det_rst_en && det_below;

  // APB decode
  wire apb_setup = I_PSEL && !I_PENABLE;
  wire apb_wr = I_PSEL && I_PENABLE && I_PWRITE;
  wire sel_c1 = (I_PADDR == OFS_PWR_CTRL_1);
  wire sel_c2 = (I_PADDR == OFS_PWR_CTRL_2);
  wire sel_c3 = (I_PADDR == OFS_PWR_CTRL_3);
  wire sel_rs = (I_PADDR == OFS_RESET_STATUS);
  wire sel_ck = (I_PADDR == OFS_CLOCK_CTRL);
  wire sel_any = sel_c1 || sel_c2 || sel_c3 || sel_rs || sel_ck;
  wire det_ack = apb_wr && sel_c1 && I_PWDATA[B_DET_ACK];
  wire warn_ack = apb_wr && sel_c3 && I_PWDATA[B_WARN_ACK];

  // Stop instruction outcome
  wire stop_req = (st_r == ST_RUN) && I_STOP_INSTR;
  wire stop_illegal = stop_req && !c2_r.stop_instr_en;
  wire deep_blocked = c1_r.det_stop_en || c2_r.debug_en;
  wire go_deep = stop_req && c2_r.stop_instr_en && c2_r.stop_deep_sel
                 && !deep_blocked && !I_IRQ_PENDING;
  wire go_retain = stop_req && c2_r.stop_instr_en
                   && (!c2_r.stop_deep_sel || deep_blocked);
  wire deep_wake = (st_r == ST_DEEP_STOP) && I_WAKE && !det_below;
  wire reset_cond = por_trip || por_hold_r || low_hold_r || ilop_r || wake_rst_r;

  // Reset hold latches: power-on and low-supply holds release only when supply clears the threshold; stop resets last one cycle
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      por_hold_r <= 1'b1;
      low_hold_r <= 1'b0;
      ilop_r <= 1'b0;
      wake_rst_r <= 1'b0;
      por_seen_r <= 1'b1;
    end else if (I_CLK_EN) begin
      if (por_trip) begin
        por_hold_r <= 1'b1;
      end else if (!det_below) begin
        por_hold_r <= 1'b0;
      end
      if (low_rst_req) begin
        low_hold_r <= 1'b1;
      end else if (!det_below) begin
        low_hold_r <= 1'b0;
      end
      ilop_r <= stop_illegal;
      wake_rst_r <= deep_wake;
      if (por_trip) begin
        por_seen_r <= 1'b1;
      end else if (st_r == ST_RUN || st_r == ST_DEBUG) begin
        por_seen_r <= 1'b0;
      end
    end
  end

  // Mode sequencer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_RESET: begin
        if (!reset_cond) begin
          if (!filt_r[A_DBG_PIN] && por_seen_r) begin
            st_nxt = ST_DEBUG;
          end else begin
            st_nxt = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (I_ENTER_DEBUG_INSTR || I_BREAKPOINT_HIT || I_CMD_BACKGROUND) begin
          st_nxt = ST_DEBUG;
        end else if (go_deep) begin
          st_nxt = ST_DEEP_STOP;
        end else if (go_retain) begin
          st_nxt = ST_RETAIN_STOP;
        end
      end
      ST_DEBUG: begin
        if (I_CMD_GO) begin
          st_nxt = ST_RUN;
        end
      end
      ST_DEEP_STOP: begin
        st_nxt = ST_DEEP_STOP; // Leaves only through the reset path
      end
      ST_RETAIN_STOP: begin
        if (I_CMD_BACKGROUND && c2_r.debug_en) begin
          st_nxt = ST_DEBUG;
        end else if (I_WAKE) begin
          st_nxt = ST_RUN;
        end
      end
      default: begin
        st_nxt = ST_RESET;
      end
    endcase
    if (reset_cond || low_rst_req || stop_illegal || por_trip) begin
      st_nxt = ST_RESET;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RESET;
    end else if (I_CLK_EN) begin
      st_r <= st_nxt;
    end
  end

  // Control registers; divide field also cleared by any chip reset
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      c1_r <= '0;
      c2_r <= '0;
      c3_r <= '0;
      bus_div_r <= BUS_DIV_RESET;
    end else if (I_CLK_EN) begin
      if (st_r == ST_RESET) begin
        bus_div_r <= BUS_DIV_RESET;
      end else if (apb_wr && sel_ck) begin
        bus_div_r <= I_PWDATA[1:0];
      end
      if (apb_wr && sel_c1) begin
        c1_r <= I_PWDATA[B_DET_IRQ_EN:B_DET_EN];
      end
      if (apb_wr && sel_c2) begin
        c2_r <= I_PWDATA[B_DEBUG_EN:B_STOP_DEEP_SEL];
      end
      if (apb_wr && sel_c3) begin
        c3_r <= I_PWDATA[B_WARN_SEL:B_THR_SEL];
      end
    end
  end

  // Sticky flags; a new event wins over an acknowledge in the same cycle
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      det_flag_r <= 1'b0;
      warn_flag_r <= 1'b0;
    end else if (I_CLK_EN) begin
      if (det_irq_evt) begin
        det_flag_r <= 1'b1;
      end else if (det_ack) begin
        det_flag_r <= 1'b0;
      end
      if (warn_below) begin
        warn_flag_r <= 1'b1;
      end else if (warn_ack) begin
        warn_flag_r <= 1'b0;
      end
    end
  end

  // Reset status: loaded with the cause when a reset begins
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rstat_r <= RSTAT_AT_POR;
    end else if (I_CLK_EN) begin
      if (por_trip) begin
        rstat_r <= RSTAT_AT_POR;
      end else if (low_rst_req && st_r != ST_RESET) begin
        rstat_r <= 4'h1 << B_RS_LOW_SUPPLY;
      end else if (stop_illegal) begin
        rstat_r <= 4'h1 << B_RS_ILLEGAL_OP;
      end else if (deep_wake) begin
        rstat_r <= 4'h1 << B_RS_STOP_WAKE;
      end
    end
  end

  // Read data captured in the setup phase so it comes from a flop
  wire [31:0] rd_mux = sel_c1 ? {26'h0, 1'b0, det_flag_r, c1_r} :
                       sel_c2 ? {29'h0, c2_r} :
                       sel_c3 ? {28'h0, 1'b0, warn_flag_r, c3_r} :
                       sel_rs ? {28'h0, rstat_r} :
                       sel_ck ? {30'h0, bus_div_r} : 32'h0;
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0;
    end else if (I_CLK_EN && apb_setup) begin
      prdata_r <= rd_mux;
    end
  end

  // Vector fetch on each exit from reset into run
  logic fetch_r;
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      fetch_r <= 1'b0;
    end else if (I_CLK_EN) begin
      fetch_r <= (st_r == ST_RESET) && (st_nxt == ST_RUN);
    end
  end

  // Outputs; interrupt only from the detect flag, never from the warning
  assign O_PRDATA = prdata_r;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !sel_any;
  assign O_LVD_IRQ = det_flag_r && c1_r.det_irq_en;
  assign O_SYS_RESET = (st_r == ST_RESET);
  assign O_BUS_CLOCK_DIVIDE = bus_div_r;
  assign O_HFO_RUN = !in_stop;
  assign O_SYS_CLK_RUN = !in_stop || ((st_r == ST_RETAIN_STOP) && c2_r.debug_en);
  assign O_LFO_RUN = 1'b1;
  assign O_CPU_SUSPEND = (st_r == ST_DEBUG) || in_stop;
  assign O_REG_STANDBY = (st_r == ST_DEEP_STOP);
  assign O_VECTOR_FETCH = fetch_r;
  assign O_VECTOR_ADDR = RESET_VECTOR_HI;
  assign O_MODE = st_r;
  // Intrusive commands only in debug; none while stopped
  assign O_CMD_ACCEPT = I_CMD_VALID && !in_stop && (!I_CMD_INTRUSIVE || st_r == ST_DEBUG);
  assign O_CMD_REJECT = I_CMD_VALID && !O_CMD_ACCEPT;

  // Checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!rst_n || !I_CLK_EN);

  sequence stop_cmd_s;
    (st_r == ST_RUN) && I_STOP_INSTR && !I_ENTER_DEBUG_INSTR && !I_BREAKPOINT_HIT
    && !I_CMD_BACKGROUND && !reset_cond && !low_rst_req && !por_trip;
  endsequence

  illegal_stop_rst_a: assert property ((stop_cmd_s and !c2_r.stop_instr_en)
    |=> st_r == ST_RESET ##1 ilop_r == 1'b0)
    else $error("stop without enable did not reset");
  deep_redirect_a: assert property ((stop_cmd_s and c2_r.stop_instr_en
    and c2_r.stop_deep_sel and deep_blocked) |=> st_r == ST_RETAIN_STOP)
    else $error("deep stop not redirected");
  deep_pending_a: assert property ((stop_cmd_s and I_IRQ_PENDING) |=> st_r != ST_DEEP_STOP)
    else $error("deep stop entered with pending interrupt");
  warn_no_irq_a: assert property ($rose(warn_flag_r) && !det_flag_r |-> !O_LVD_IRQ)
    else $error("warning raised interrupt");
  warn_hold_a: assert property (warn_below && warn_flag_r |=> warn_flag_r)
    else $error("warning flag cleared while low");
  div_clear_a: assert property (st_r == ST_RESET |=> bus_div_r == 2'h0)
    else $error("divide field not cleared by reset");
  rst_hold_a: assert property (low_hold_r && det_below |=> st_r == ST_RESET [*2])
    else $error("reset released while supply low");
  det_irq_a: assert property (det_irq_evt |=> det_flag_r ##0 O_LVD_IRQ)
    else $error("detect flag or interrupt missing");
  stop_clk_a: assert property (in_stop && !c2_r.debug_en |-> !O_SYS_CLK_RUN && !O_HFO_RUN
    && O_LFO_RUN)
    else $error("clocks running in stop");
  por_flags_a: assert property (por_trip |=> rstat_r == RSTAT_AT_POR)
    else $error("power-on status flags missing");
  intrusive_a: assert property (I_CMD_VALID && I_CMD_INTRUSIVE && st_r != ST_DEBUG
    |-> O_CMD_REJECT)
    else $error("intrusive command accepted outside debug");

endmodule

// [tb/lvpm_supply_model.sv]
`timescale 1ns/1ps
// Supply comparators: level 5 is healthy, each step down crosses one more trip
module lvpm_supply_model (
  input wire logic [2:0] i_level,
  output logic o_por,
  output logic o_det_hi,
  output logic o_det_lo,
  output logic o_warn_hi,
  output logic o_warn_lo
);
  // Warning trips sit above detect trips so a warning always comes first
  assign o_warn_hi = (i_level <= 3'h4);
  assign o_warn_lo = (i_level <= 3'h3);
  assign o_det_hi = (i_level <= 3'h2);
  assign o_det_lo = (i_level <= 3'h1);
  assign o_por = (i_level == 3'h0);
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  import lvpm_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, dpin = 1'b1, stop = 1'b0, dbgi = 1'b0;
  logic bkpt = 1'b0, pend = 1'b0, wake = 1'b0, cval = 1'b0, cintr = 1'b0, cbg = 1'b0, cgo = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, d;
  logic [2:0] level = 3'h0;
  logic pready, pslverr, err, accept, reject, sysrst, irq, high_freq_oscillator, sclk, low_freq_oscillator, susp, stby, vf;
  logic por, dhi, dlo, whi, wlo;
  logic [1:0] div;
  logic [15:0] vaddr;
  logic [4:0] mode, m;
  logic [3:0] c1;
  logic [2:0] c2;
  logic p;
  int errors = 0;
  int checks = 0;

  // 100 ns period
  always #50 clk = ~clk;

  lvpm_supply_model supply (.i_level(level), .o_por(por), .o_det_hi(dhi), .o_det_lo(dlo),
    .o_warn_hi(whi), .o_warn_lo(wlo));

  lvpm_ctrl dut (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_CLK_EN(1'b1), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_POR_TRIP(por), .I_DET_BELOW_HI(dhi),
    .I_DET_BELOW_LO(dlo), .I_WARN_BELOW_HI(whi), .I_WARN_BELOW_LO(wlo),
    .I_DEBUG_MODE_PIN(dpin), .I_STOP_INSTR(stop), .I_ENTER_DEBUG_INSTR(dbgi),
    .I_BREAKPOINT_HIT(bkpt), .I_IRQ_PENDING(pend), .I_WAKE(wake), .I_CMD_VALID(cval),
    .I_CMD_INTRUSIVE(cintr), .I_CMD_BACKGROUND(cbg), .I_CMD_GO(cgo), .O_CMD_ACCEPT(accept),
    .O_CMD_REJECT(reject), .O_SYS_RESET(sysrst), .O_LVD_IRQ(irq), .O_BUS_CLOCK_DIVIDE(div),
    .O_HFO_RUN(high_freq_oscillator), .O_SYS_CLK_RUN(sclk), .O_LFO_RUN(low_freq_oscillator), .O_CPU_SUSPEND(susp),
    .O_REG_STANDBY(stby), .O_VECTOR_FETCH(vf), .O_VECTOR_ADDR(vaddr), .O_MODE(mode));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Bounded wait; a hang is counted and ends the run
  task automatic timeout(input int n);
    if (n >= 60) begin
      errors++;
      report_and_stop();
    end
  endtask

  // APB transfer held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    int n;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 60);
    timeout(n);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // Idle edge so the write has landed and the next setup is a fresh assignment
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  // Re-read until the masked bits match; flags lag the comparators a few edges
  task automatic poll(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] val);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((q & mask) !== val && n < 60);
    timeout(n);
    check(q & mask, val);
  endtask

  task automatic wait_mode(input logic [4:0] want);
    int n;
    n = 0;
    while (mode !== want && n < 60) begin
      @(posedge clk);
      n++;
    end
    timeout(n);
    check(mode, want);
  endtask

  task automatic pulse_stop();
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    tick(2);
  endtask

  // Stop mode that a request should land in
  function automatic logic [4:0] stop_mode(input logic [3:0] r1, input logic [2:0] r2,
                                           input logic pe);
    if (r2[B_STOP_DEEP_SEL] && pe) begin
      return ST_RUN;
    end
    if (r2[B_STOP_DEEP_SEL] && !r1[B_DET_STOP_EN] && !r2[B_DEBUG_EN]) begin
      return ST_DEEP_STOP;
    end
    return ST_RETAIN_STOP;
  endfunction

  initial begin
    void'($urandom(40));
    tick(3);
    check(mode, ST_RESET);
    tick(3);
    rstn <= 1'b1;
    tick(20);
    check(mode, ST_RESET);
    level <= 3'h5;
    wait_mode(ST_RUN);
    check(vf, 1'b1);
    check(vaddr, RESET_VECTOR_HI);
    rd(OFS_RESET_STATUS, RSTAT_AT_POR);
    rd(OFS_CLOCK_CTRL, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check(err, 1'b1);
    // All divide codes with random upper data bits
    for (int i = 0; i < 4; i++) begin
      d = ($urandom << 2) | i;
      apb(1'b1, OFS_CLOCK_CTRL, d);
      check(div, d[1:0]);
      rd(OFS_CLOCK_CTRL, d & 32'h3);
    end
    // Low supply reset, held while low
    apb(1'b1, OFS_PWR_CTRL_1, 32'h5);
    level <= 3'h1;
    wait_mode(ST_RESET);
    tick(10);
    check(sysrst, 1'b1);
    level <= 3'h5;
    wait_mode(ST_RUN);
    rd(OFS_RESET_STATUS, 32'h2);
    // Interrupt mode; low threshold ignores a dip to level 2
    apb(1'b1, OFS_PWR_CTRL_1, 32'h9);
    level <= 3'h2;
    tick(10);
    check(irq, 1'b0);
    apb(1'b1, OFS_PWR_CTRL_3, 32'h1);
    poll(OFS_PWR_CTRL_1, 32'h10, 32'h10);
    check(irq, 1'b1);
    level <= 3'h5;
    tick(10);
    apb(1'b1, OFS_PWR_CTRL_1, 32'h29);
    rd(OFS_PWR_CTRL_1, 32'h9);
    // Warning levels, ack refused while still low; first clear the flag from earlier dips
    apb(1'b1, OFS_PWR_CTRL_3, 32'h8);
    level <= 3'h4;
    tick(10);
    rd(OFS_PWR_CTRL_3, 32'h0);
    apb(1'b1, OFS_PWR_CTRL_3, 32'h2);
    poll(OFS_PWR_CTRL_3, 32'h4, 32'h4);
    check(irq, 1'b0);
    apb(1'b1, OFS_PWR_CTRL_3, 32'ha);
    rd(OFS_PWR_CTRL_3, 32'h6);
    level <= 3'h5;
    tick(10);
    apb(1'b1, OFS_PWR_CTRL_3, 32'ha);
    rd(OFS_PWR_CTRL_3, 32'h2);
    apb(1'b1, OFS_PWR_CTRL_3, 32'h0);
    // Every mix of detector, stop-detector, deep-select and debug enables; pending only without stop detector or debug
    for (int i = 0; i < 16; i++) begin
      c1 = {2'b00, i[1], i[0]};
      c2 = {i[3], 1'b1, i[2]};
      p = 1'($urandom) & !i[1] & !i[3];
      m = stop_mode(c1, c2, p);
      apb(1'b1, OFS_PWR_CTRL_1, {28'h0, c1});
      apb(1'b1, OFS_PWR_CTRL_2, {29'h0, c2});
      pend <= p;
      pulse_stop();
      check(mode, m);
      if (m != ST_RUN) begin
        check(high_freq_oscillator, 1'b0);
        check(low_freq_oscillator, 1'b1);
        check(sclk, c2[B_DEBUG_EN]);
        check(stby, m == ST_DEEP_STOP);
      end
      pend <= 1'b0;
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      wait_mode(ST_RUN);
      if (m == ST_DEEP_STOP) begin
        check(vf, 1'b1);
        rd(OFS_RESET_STATUS, 32'h8);
      end
    end
    // Deep stop waits for the supply before waking
    apb(1'b1, OFS_PWR_CTRL_1, 32'h0);
    apb(1'b1, OFS_PWR_CTRL_2, 32'h3);
    pulse_stop();
    level <= 3'h1;
    tick(10);
    wake <= 1'b1;
    tick(10);
    check(mode, ST_DEEP_STOP);
    level <= 3'h5;
    wait_mode(ST_RUN);
    wake <= 1'b0;
    // Detector off in retained stop without its stop enable
    apb(1'b1, OFS_PWR_CTRL_1, 32'h5);
    apb(1'b1, OFS_PWR_CTRL_2, 32'h2);
    pulse_stop();
    level <= 3'h1;
    tick(10);
    check(mode, ST_RETAIN_STOP);
    level <= 3'h5;
    tick(10);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    wait_mode(ST_RUN);
    // Stop without enable resets and clears the divider
    apb(1'b1, OFS_CLOCK_CTRL, 32'h3);
    apb(1'b1, OFS_PWR_CTRL_2, 32'h0);
    pulse_stop();
    wait_mode(ST_RESET);
    wait_mode(ST_RUN);
    check(div, 2'h0);
    rd(OFS_RESET_STATUS, 32'h4);
    // Three run-time debug entries, commands, then go
    for (int k = 0; k < 3; k++) begin
      dbgi <= (k == 0);
      bkpt <= (k == 1);
      cbg <= (k == 2);
      @(posedge clk);
      {dbgi, bkpt, cbg} <= 3'h0;
      tick(2);
      check(mode, ST_DEBUG);
      check(susp, 1'b1);
      cval <= 1'b1;
      cintr <= 1'b1;
      tick(1);
      check(accept, 1'b1);
      cval <= 1'b0;
      cgo <= 1'b1;
      @(posedge clk);
      cgo <= 1'b0;
      wait_mode(ST_RUN);
      cval <= 1'b1;
      tick(1);
      check(reject, 1'b1);
      cintr <= 1'b0;
      tick(1);
      check(accept, 1'b1);
      cval <= 1'b0;
    end
    // Power-up with the debug pin low enters debug
    rstn <= 1'b0;
    dpin <= 1'b0;
    tick(6);
    rstn <= 1'b1;
    wait_mode(ST_DEBUG);
    report_and_stop();
  end
endmodule
